/* rtl/fdo_pkg.sv */
// Constants, register map and pin carriers for the floppy drive control outputs.
// Assumes a 250 MHz core clock and an AHB-Lite register port with 32-bit data.
package fdo_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int STEP_PULSE_NS = 1000;
    localparam int STEP_PULSE_CYCLES = (STEP_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STEP_UNIT_NS = 1000000;
    localparam int STEP_UNIT_CYCLES = STEP_UNIT_NS / CLOCK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_DRIVE_CTRL = 8'h00;
    localparam logic [7:0] OFF_DATA_RATE = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_SPECIFY = 8'h0c;
    localparam logic [7:0] OFF_SEEK = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int NUM_DRIVES = 4;
    localparam int SEEK_CNT_W = 12;
    localparam int STEP_RATE_W = 4;
    localparam logic [7:0] DRIVE_CTRL_RST = 8'h00;
    localparam logic MODE_PUMP_SEL_RST = 1'b0;
    localparam logic [3:0] SPECIFY_INIT = 4'h0;
    localparam int ST_BUSY = 0;
    localparam int ST_PRECOMP = 1;
    localparam int ST_STRAP = 2;
    localparam int ST_PUMP = 3;
    localparam int ST_SPEED = 4;
    localparam int ST_STEP_RB = 5;
    localparam int ST_MOTOR_RB = 8;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [1:0] {
        RATE_500 = 2'b00,
        RATE_300 = 2'b01,
        RATE_250 = 2'b10,
        RATE_1M = 2'b11
    } fdo_rate_t;

    localparam fdo_rate_t DATA_RATE_RST = RATE_250;

    // ----------------------------------------------------------------
    // Drive-side pins
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_DRIVES-1:0] motor_enable_n_o;
        logic [NUM_DRIVES-1:0] motor_enable_n_oe;
        logic spindle_speed_or_low_current_o;
        logic spindle_speed_or_low_current_oe;
        logic step_n_o;
        logic step_n_oe;
        logic charge_corr_or_precomp_sel_o;
        logic charge_corr_or_precomp_sel_oe;
    } fdo_drive_out_t;

    typedef struct packed {
        logic [NUM_DRIVES-1:0] motor_enable_n_i;
        logic spindle_speed_or_low_current_i;
        logic step_n_i;
        logic charge_corr_or_precomp_sel_i;
        logic drive_type_strap;
    } fdo_drive_in_t;

endpackage

/* rtl/fdo_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes asynchronous inputs; output moves only when stages two and three agree.
`timescale 1ns/100ps
module fdo_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    import fdo_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit takes a new value only once two later stages hold it alike.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            level <= '0;
        end else begin
            level <= (stage2 & stage3) | (level & (stage2 | stage3));
        end
    end
endmodule

/* rtl/fdo_step_gen.sv */
// Step pulse sequencer for seeks.
// Assumes start is a one-cycle pulse; a start while busy is ignored.
`timescale 1ns/100ps
module fdo_step_gen #(
    parameter int UNIT_CYCLES = fdo_pkg::STEP_UNIT_CYCLES,
    parameter int PULSE_CYCLES = fdo_pkg::STEP_PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [fdo_pkg::SEEK_CNT_W-1:0] steps,
    input wire logic [fdo_pkg::STEP_RATE_W-1:0] step_rate,
    output logic step_active,
    output logic busy,
    output logic [fdo_pkg::SEEK_CNT_W-1:0] remaining
);
    import fdo_pkg::*;

    typedef enum logic [1:0] {
        SG_IDLE = 2'b00,
        SG_PULSE = 2'b01,
        SG_GAP = 2'b10
    } fdo_step_state_t;

    fdo_step_state_t state;
    logic [23:0] cnt;
    logic [23:0] gap_load;

    // The gap is (16 - rate) time units, so rate 0 is the slowest.
    assign gap_load = 24'(UNIT_CYCLES * int'(5'h10 - {1'b0, step_rate}) - 1);
    assign step_active = (state == SG_PULSE);
    assign busy = (state != SG_IDLE);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= SG_IDLE;
            cnt <= '0;
            remaining <= '0;
        end else begin
            case (state)
                SG_IDLE: begin
                    if (start && steps != '0) begin
                        state <= SG_PULSE;
                        cnt <= 24'(PULSE_CYCLES - 1);
                        remaining <= steps;
                    end
                end
                SG_PULSE: begin
                    if (cnt == '0) begin
                        state <= SG_GAP;
                        cnt <= gap_load;
                        remaining <= remaining - 1'b1;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                SG_GAP: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else if (remaining == '0) begin
                        state <= SG_IDLE;
                    end else begin
                        state <= SG_PULSE;
                        cnt <= 24'(PULSE_CYCLES - 1);
                    end
                end
                default: begin
                    state <= SG_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_step_start: assert property (@(posedge clock) disable iff (!rst_b)
        (!busy && start && steps != '0) |=> step_active [*2])
        else $error("step pulse did not begin after seek start");
    chk_step_count: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(step_active) |-> (remaining == $past(remaining) - 1'b1) && busy)
        else $error("step count did not fall by one per pulse");
endmodule

/* rtl/fdo_top.sv */
// Drive-side control outputs: motor enables, speed or write current, step, pump pin.
// Assumes one 250 MHz clock, an AHB-Lite master and open-drain pads outside.
`timescale 1ns/100ps

module fdo_top #(
    parameter int STEP_UNIT_CYCLES = fdo_pkg::STEP_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    input wire logic pump_correcting,
    output logic precomp_mode_sel,
    input wire fdo_pkg::fdo_drive_in_t drive_in,
    output fdo_pkg::fdo_drive_out_t drive_out
);
    import fdo_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic dp_word;
    logic [7:0] dp_addr;
    logic rd_wait;
    logic take;
    logic wr_en;
    logic [31:0] next_rdata;

    assign take = hsel && htrans[1] && hready;
    // Writes are also gated by reset, so no register write can land while reset is held.
    assign wr_en = dp_valid && dp_write && dp_word && rst_b;
    assign hreadyout = !rd_wait;
    assign hresp = HRESP_OKAY;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_word <= 1'b0;
            dp_addr <= '0;
        end else if (hready) begin
            dp_valid <= take;
            dp_write <= hwrite;
            dp_word <= (hsize == HSIZE_WORD);
            dp_addr <= haddr[7:0];
        end
    end

    // Reads take one wait state so the data come from a flip-flop.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_wait <= 1'b0;
            hrdata <= '0;
        end else begin
            rd_wait <= take && !hwrite;
            if (rd_wait) begin
                hrdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] drive_ctrl;
    fdo_rate_t data_rate;
    logic pump_indicator_select;
    logic [STEP_RATE_W-1:0] step_rate = SPECIFY_INIT;
    logic seek_start;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            drive_ctrl <= DRIVE_CTRL_RST;
        end else if (wr_en && dp_addr == OFF_DRIVE_CTRL) begin
            drive_ctrl <= hwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            data_rate <= DATA_RATE_RST;
        end else if (wr_en && dp_addr == OFF_DATA_RATE) begin
            data_rate <= fdo_rate_t'(hwdata[1:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pump_indicator_select <= MODE_PUMP_SEL_RST;
        end else if (wr_en && dp_addr == OFF_MODE) begin
            pump_indicator_select <= hwdata[0];
        end
    end

    // Timing set by software survives reset; it is loaded only by writes.
    always_ff @(posedge clock) begin
        if (wr_en && dp_addr == OFF_SPECIFY) begin
            step_rate <= hwdata[STEP_RATE_W-1:0];
        end
    end

    assign seek_start = wr_en && dp_addr == OFF_SEEK;

    // ----------------------------------------------------------------
    // Pin inputs and seek engine
    // ----------------------------------------------------------------
    logic [7:0] pins_raw;
    logic [7:0] pins_sync;
    logic strap;
    logic precomp_pin;
    logic step_active;
    logic seek_busy;
    logic [SEEK_CNT_W-1:0] seek_remaining;

    assign pins_raw = {drive_in.motor_enable_n_i, drive_in.spindle_speed_or_low_current_i,
                       drive_in.step_n_i, drive_in.charge_corr_or_precomp_sel_i, drive_in.drive_type_strap};
    assign strap = pins_sync[0];
    assign precomp_pin = pins_sync[1];

    fdo_sync #(
        .WIDTH(8)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .pin(pins_raw),
        .level(pins_sync)
    );

    fdo_step_gen #(
        .UNIT_CYCLES(STEP_UNIT_CYCLES),
        .PULSE_CYCLES(STEP_PULSE_CYCLES)
    ) u_step (
        .clock(clock),
        .rst_b(rst_b),
        .start(seek_start),
        .steps(hwdata[SEEK_CNT_W-1:0]),
        .step_rate(step_rate),
        .step_active(step_active),
        .busy(seek_busy),
        .remaining(seek_remaining)
    );

    always_comb begin
        next_rdata = '0;
        case (dp_addr)
            OFF_DRIVE_CTRL: next_rdata[7:0] = drive_ctrl;
            OFF_DATA_RATE: next_rdata[1:0] = data_rate;
            OFF_MODE: next_rdata[0] = pump_indicator_select;
            OFF_SPECIFY: next_rdata[STEP_RATE_W-1:0] = step_rate;
            OFF_SEEK: next_rdata[SEEK_CNT_W-1:0] = seek_remaining;
            OFF_STATUS: begin
                next_rdata[ST_BUSY] = seek_busy;
                next_rdata[ST_PRECOMP] = precomp_mode_sel;
                next_rdata[ST_STRAP] = strap;
                next_rdata[ST_PUMP] = pump_correcting;
                next_rdata[ST_SPEED] = pins_sync[3];
                next_rdata[ST_STEP_RB] = pins_sync[2];
                next_rdata[ST_MOTOR_RB +: NUM_DRIVES] = pins_sync[7:4];
            end
            default: next_rdata = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Drive-side outputs
    // ----------------------------------------------------------------
    logic [NUM_DRIVES-1:0] motor_oe;
    logic speed_oe;
    logic step_oe;
    logic pump_oe;
    logic pump_o;
    logic high_rate;

    // Open-drain: enable pulls low, so an active-low enable is driven while set.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DRIVES; gi++) begin : g_motor
            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    motor_oe[gi] <= 1'b0;
                end else begin
                    motor_oe[gi] <= drive_ctrl[gi];
                end
            end
        end
    endgenerate

    // Both strap settings want the pin low below 500 kb/s and released at 500 kb/s and above.
    assign high_rate = (data_rate == RATE_500) || (data_rate == RATE_1M);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            speed_oe <= 1'b0;
            step_oe <= 1'b0;
            pump_oe <= 1'b0;
            pump_o <= 1'b0;
            precomp_mode_sel <= 1'b0;
        end else begin
            speed_oe <= strap ? !high_rate : !high_rate;
            step_oe <= step_active;
            pump_oe <= pump_indicator_select;
            pump_o <= pump_correcting;
            precomp_mode_sel <= pump_indicator_select ? 1'b1 : precomp_pin;
        end
    end

    always_comb begin
        drive_out = '0;
        drive_out.motor_enable_n_oe = motor_oe;
        drive_out.spindle_speed_or_low_current_oe = speed_oe;
        drive_out.step_n_oe = step_oe;
        drive_out.charge_corr_or_precomp_sel_o = pump_o;
        drive_out.charge_corr_or_precomp_sel_oe = pump_oe;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Most checks look one cycle after their trigger, which allows for the flop on each output.
    sequence s_drive_ctrl_write;
        wr_en && dp_addr == OFF_DRIVE_CTRL;
    endsequence

    sequence s_reset_cycle;
        !rst_b;
    endsequence

    sequence s_mode_clear;
        !pump_indicator_select ##1 rst_b;
    endsequence

    chk_motor_follow: assert property (@(posedge clock) disable iff (!rst_b)
        s_drive_ctrl_write ##1 rst_b |=> motor_oe == $past(hwdata[3:0], 2))
        else $error("motor pins do not follow drive control write");
    chk_pump_dir: assert property (@(posedge clock) disable iff (!rst_b)
        pump_indicator_select ##1 pump_indicator_select |-> pump_oe && pump_o == $past(pump_correcting))
        else $error("shared pin not driving pump state");
    chk_precomp_forced: assert property (@(posedge clock) disable iff (!rst_b)
        pump_indicator_select |=> precomp_mode_sel)
        else $error("precomp selection not forced high");
    chk_reset_release: assert property (@(posedge clock)
        s_reset_cycle |=> drive_out.motor_enable_n_oe == '0 && !speed_oe && !step_oe && !pump_oe && !seek_busy)
        else $error("drive outputs not released by reset");
    chk_reset_ctrl: assert property (@(posedge clock)
        s_reset_cycle |=> drive_ctrl == DRIVE_CTRL_RST)
        else $error("drive control not cleared by reset");
    chk_reset_rate: assert property (@(posedge clock)
        s_reset_cycle |=> data_rate == RATE_250)
        else $error("data rate not 250 kb/s after reset");
    chk_specify_kept: assert property (@(posedge clock)
        s_reset_cycle |=> step_rate == $past(step_rate))
        else $error("step timing changed by reset");
    chk_mode_default: assert property (@(posedge clock)
        s_reset_cycle |=> pump_indicator_select == MODE_PUMP_SEL_RST)
        else $error("mode not at default after reset");
    chk_speed_pin: assert property (@(posedge clock) disable iff (!rst_b)
        (data_rate == RATE_250 || data_rate == RATE_300) ##1 rst_b |-> speed_oe)
        else $error("speed pin not low at low rate");
    chk_low_current: assert property (@(posedge clock) disable iff (!rst_b)
        (data_rate == RATE_500) ##1 rst_b |-> !speed_oe)
        else $error("speed pin not released at 500 kb/s");
    chk_step_pin: assert property (@(posedge clock) disable iff (!rst_b)
        step_active ##1 rst_b |-> step_oe)
        else $error("step pin not low during step pulse");
    chk_pump_release: assert property (@(posedge clock) disable iff (!rst_b)
        s_mode_clear |-> !pump_oe && precomp_mode_sel == $past(precomp_pin))
        else $error("shared pin not released as precomp input");
    chk_fast_rate: assert property (@(posedge clock) disable iff (!rst_b)
        (data_rate == RATE_1M) ##1 rst_b |-> !speed_oe)
        else $error("speed pin not released at 1 Mb/s");
    chk_motor_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (rst_b && !(wr_en && dp_addr == OFF_DRIVE_CTRL)) ##1 rst_b |-> $stable(drive_ctrl))
        else $error("drive control changed without a write");
    chk_read_data: assert property (@(posedge clock) disable iff (!rst_b)
        rd_wait |=> hreadyout && hrdata == $past(next_rdata))
        else $error("read data not presented after one wait state");
endmodule

/* test/fdo_drive_model.sv */
// Drive-side model: pull-ups on the open-drain pins, the strap and the precomp level.
// Assumes drive_out of fdo_top; measures step pulses in clock cycles.
`timescale 1ns/100ps
module fdo_drive_model (
    input wire logic clock,
    input wire fdo_pkg::fdo_drive_out_t drive_out,
    input wire logic strap,
    input wire logic precomp_level,
    input wire logic clear,
    output fdo_pkg::fdo_drive_in_t drive_in,
    output int pulses,
    output int width,
    output int gap
);
    import fdo_pkg::*;
    int lo_run;
    int hi_run;
    // A released open-drain pin floats up to the pull-up level; the released shared pin takes precomp_level.
    assign drive_in.motor_enable_n_i = ~drive_out.motor_enable_n_oe;
    assign drive_in.spindle_speed_or_low_current_i = ~drive_out.spindle_speed_or_low_current_oe;
    assign drive_in.step_n_i = ~drive_out.step_n_oe;
    assign drive_in.charge_corr_or_precomp_sel_i = drive_out.charge_corr_or_precomp_sel_oe ?
        drive_out.charge_corr_or_precomp_sel_o : precomp_level;
    assign drive_in.drive_type_strap = strap;
    always @(posedge clock) begin
        if (clear) begin
            pulses <= 0;
            lo_run <= 0;
            hi_run <= 0;
        end else if (drive_out.step_n_oe) begin
            if (lo_run == 0) begin
                pulses <= pulses + 1;
                gap <= hi_run;
            end
            lo_run <= lo_run + 1;
            hi_run <= 0;
        end else begin
            if (lo_run != 0) begin
                width <= lo_run;
            end
            lo_run <= 0;
            hi_run <= hi_run + 1;
        end
    end
endmodule

/* test/floppy_drive_control_outputs_tb.sv */
// Self-checking bench for the drive-side control outputs.
// Assumes fdo_top as the only AHB-Lite slave and fdo_drive_model on the pins.
`timescale 1ns/100ps
module floppy_drive_control_outputs_tb;
    import fdo_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [1:0] hresp;
    logic [31:0] hrdata;
    logic pump_correcting = 1'b0;
    logic precomp_mode_sel;
    logic strap = 1'b0;
    logic precomp_level = 1'b1;
    logic clear = 1'b1;
    fdo_drive_in_t drive_in;
    fdo_drive_out_t drive_out;
    int pulses;
    int width;
    int gap;
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [7:0] all_oe;
    assign all_oe = {drive_out.motor_enable_n_oe, drive_out.spindle_speed_or_low_current_oe,
        drive_out.step_n_oe, drive_out.charge_corr_or_precomp_sel_oe, precomp_mode_sel};

    always #2 clock = ~clock;

    fdo_top #(.STEP_UNIT_CYCLES(20)) u_fdo_top (.clock(clock), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pump_correcting(pump_correcting), .precomp_mode_sel(precomp_mode_sel),
        .drive_in(drive_in), .drive_out(drive_out));
    fdo_drive_model u_fdo_drive_model (.clock(clock), .drive_out(drive_out), .strap(strap),
        .precomp_level(precomp_level), .clear(clear), .drive_in(drive_in), .pulses(pulses),
        .width(width), .gap(gap));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for hready high at a rising edge; hready and hrdata are sampled at the falling edge before it.
    task automatic bus_wait();
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        while (!ok) begin
            @(negedge clock);
            ok = (hreadyout === 1'b1);
            rd = hrdata;
            @(posedge clock);
            n++;
            if (n > 50) begin
                mismatches++;
                stop_test();
            end
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic t_defaults();
        bus(1'b0, OFF_DRIVE_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(32'(hresp), 32'(HRESP_OKAY));
        bus(1'b0, OFF_DATA_RATE, 32'h0);
        chk(rd, 32'(DATA_RATE_RST));
        bus(1'b0, OFF_MODE, 32'h0);
        chk(rd, 32'h0);
        $display("defaults done");
    endtask

    task automatic t_motor();
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, OFF_DRIVE_CTRL, 32'(i));
            settle(2);
            chk(32'(drive_out.motor_enable_n_oe), 32'(i));
            settle(6);
            bus(1'b0, OFF_STATUS, 32'h0);
            chk(32'(rd[11:8]), 32'(~i & 15));
        end
        chk(32'({drive_out.motor_enable_n_o, drive_out.spindle_speed_or_low_current_o, drive_out.step_n_o}), 32'h0);
        $display("motor done");
    endtask

    task automatic t_rate();
        for (int s = 0; s < 2; s++) begin
            @(posedge clock);
            strap <= s[0];
            for (int c = 0; c < 4; c++) begin
                bus(1'b1, OFF_DATA_RATE, 32'(c));
                settle(2);
                chk(32'(drive_out.spindle_speed_or_low_current_oe), 32'(c == 1 || c == 2));
            end
            bus(1'b0, OFF_STATUS, 32'h0);
            chk(32'(rd[ST_STRAP]), 32'(s));
        end
        bus(1'b1, OFF_DATA_RATE, 32'(RATE_250));
        $display("rate done");
    endtask

    task automatic t_pump();
        @(posedge clock);
        precomp_level <= 1'b0;
        settle(8);
        chk(32'({drive_out.charge_corr_or_precomp_sel_oe, precomp_mode_sel}), 32'h0);
        bus(1'b1, OFF_MODE, 32'h1);
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            pump_correcting <= p[0];
            settle(3);
            chk(32'({drive_out.charge_corr_or_precomp_sel_oe, drive_out.charge_corr_or_precomp_sel_o}),
                32'({1'b1, p[0]}));
            chk(32'(precomp_mode_sel), 32'h1);
        end
        bus(1'b1, OFF_MODE, 32'h0);
        @(posedge clock);
        precomp_level <= 1'b1;
        settle(8);
        chk(32'({drive_out.charge_corr_or_precomp_sel_oe, precomp_mode_sel}), 32'h1);
        $display("pump done");
    endtask

    task automatic t_seek();
        bus(1'b1, OFF_SPECIFY, 32'he);
        @(posedge clock);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        bus(1'b1, OFF_SEEK, 32'h3);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(32'(rd[ST_BUSY]), 32'h1);
        bus(1'b1, OFF_SEEK, 32'h9);
        for (int k = 0; k < 400 && rd[ST_BUSY] !== 1'b0; k++) begin
            bus(1'b0, OFF_STATUS, 32'h0);
        end
        chk(32'(rd[ST_BUSY]), 32'h0);
        chk(32'(pulses), 32'h3);
        chk(32'(width), 32'(STEP_PULSE_CYCLES));
        chk(32'(gap), 32'((16 - 14) * 20));
        $display("seek done");
    endtask

    task automatic t_bus_edges();
        bus(1'b1, 8'h18, 32'hff);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        @(posedge clock);
        hsize <= 3'h0;
        bus(1'b1, OFF_DRIVE_CTRL, 32'h0);
        hsize <= HSIZE_WORD;
        bus(1'b0, OFF_DRIVE_CTRL, 32'h0);
        chk(rd, 32'hf);
        $display("bus edges done");
    endtask

    task automatic t_reset_seek();
        bus(1'b1, OFF_MODE, 32'h1);
        bus(1'b1, OFF_SEEK, 32'h2);
        settle(4);
        chk(32'(drive_out.step_n_oe), 32'h1);
        @(posedge clock);
        rst_b <= 1'b0;
        settle(2);
        chk(32'(all_oe), 32'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        t_defaults();
        bus(1'b0, OFF_SPECIFY, 32'h0);
        chk(rd, 32'he);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(32'(rd[ST_BUSY]), 32'h0);
        $display("reset in seek done");
    endtask

    initial begin
        #(20000 * 4);
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk(32'(all_oe), 32'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        clear <= 1'b0;
        t_defaults();
        t_motor();
        t_rate();
        t_pump();
        t_seek();
        t_bus_edges();
        t_reset_seek();
        stop_test();
    end
endmodule
